// ===== core/seq_pkg.sv
package seq_pkg;
   // APB byte addresses
   localparam logic [7:0] ctrl_addr = 8'h00;
   localparam logic [7:0] cmd_addr = 8'h04;
   localparam logic [7:0] timing_addr = 8'h08;
   localparam logic [7:0] sync_addr = 8'h0c;
   localparam logic [7:0] gain_addr = 8'h10;
   localparam logic [7:0] status_addr = 8'h14;
   // Control fields
   localparam int single_shot_bit = 0;
   localparam int bulb_hold_bit = 1;
   localparam int global_release_bit = 2;
   localparam int trig_flip_bit = 3;
   // Command fields
   localparam int trigger_bit = 0;
   localparam int restart_bit = 1;
   // Sync register fields
   localparam int lead_lsb = 0;
   localparam int trail_lsb = 2;
   localparam int sync_enable_bit = 4;
   localparam int sync_invert_bit = 5;
   localparam logic [1:0] pt_exposure_start = 2'h1;
   localparam logic [1:0] pt_counter_expiry = 2'h2;
   localparam logic [1:0] pt_second_trigger = 2'h3;
   localparam logic [1:0] lead_reset = 2'h1;
   localparam logic [1:0] trail_reset = 2'h3;
   // Timing
   localparam int aclk_div = 2;
   localparam int all_reset_rows = 16;
   localparam int all_reset_aclks = 2004;
   localparam int blank_guard_rows = 8;
   localparam logic [15:0] exposure_rows_reset = 16'h0010;
   localparam logic [15:0] line_aclks_reset = 16'h0040;
   localparam logic [7:0] vblank_reset = 8'h19;
   // Datapath: gain is 1 + g/8, g 0..120; offset signed 12 bit
   localparam logic [6:0] dgain_reset = 7'h00;
   localparam int gain_frac_bits = 3;
   localparam int pix_w = 12;
   localparam int pix_max = 4095;
   typedef enum logic [2:0] {st_allreset, st_wait_first, st_expose, st_readout, st_blank} seq_state_t;
endpackage : seq_pkg

// ===== core/exposure_trigger_strobe_sequencer.sv
// How it works
// - Default settings give free-running frames with rolling timed exposure.
// - Single-shot set: a frame is captured only after a trigger.
// - Global release field picks global-release exposure, else rolling.
// - Rolling bulb: first trigger starts exposure, second ends it, starts readout.
// - Global single-shot without bulb: readout after exposure row count rows.
// - Every mode waits first trigger, exposes, waits second trigger, reads out.
// - Single-shot first trigger is low pin or trigger write; else automatic.
// - Polarity flip makes a high pin the first trigger; writes still count.
// - Trigger is level sensitive; held level keeps frames at frame period.
// - Without bulb, second trigger is internal after exposure row count rows.
// - Bulb second trigger is high pin, low when flipped, or restart write.
// - After a frame return to waiting; host respects blank-8 or reset spacing.
// - Sync asserts at lead code point, deasserts at trail code point.
// - Same lead and trail code gives a one array clock sync pulse; every sync point falls while frame valid is low.
// - Sync point after frame valid ends gives one array clock pulse.
// - Sync invert bit flips polarity; enable bit allows sync drive.
// - Default sync spans all-rows exposure shortened by vertical blank.
// - Pixel times digital gain 1..16, then signed offset -2048..2047 added.
// - Result is a 12-bit value per pixel on the pixel bus.
// - Hold all rows in reset 16 x 2004 array clocks before such frames.
// - Array clock period is two pixel clock periods.
// - Restart field clears itself once the restart is carried out.
//
// The register addresses and the APB slave port were decided locally.
`timescale 1ns/100ps
module exposure_trigger_strobe_sequencer #(
   parameter int frame_rows = 1944,
   parameter int all_reset_cycles = seq_pkg::all_reset_rows * seq_pkg::all_reset_aclks * seq_pkg::aclk_div
)(
   input wire logic pclk,
   input wire logic presetn,
   input wire logic psel,
   input wire logic penable,
   input wire logic pwrite,
   input wire logic [7:0] paddr,
   input wire logic [31:0] pwdata,
   output logic [31:0] prdata,
   output logic pready,
   output logic pslverr,
   input wire logic trigger_pin,
   input wire logic pix_valid_in,
   input wire logic [11:0] pix_in,
   input wire logic [1:0] pix_colour,
   output logic [11:0] pix_out,
   output logic pix_valid_out,
   output logic frame_valid,
   output logic sync_out,
   output logic sync_oe_n
);
   // Registers
   logic [3:0] ctrl_q;
   logic restart_q;
   logic trig_req_q;
   logic [15:0] exposure_row_count_q;
   logic [15:0] line_aclks_q;
   logic [7:0] vertical_blank_rows_q;
   logic [5:0] sync_cfg_q;
   logic [6:0] dgain_q [4];
   logic signed [11:0] doffset_q [4];
   logic [31:0] prdata_q;
   logic pslverr_q;
   logic pready_q;
   // Sequencer state
   seq_pkg::seq_state_t state_q;
   logic aclk_q;
   logic [15:0] aclk_cnt_q;
   logic [15:0] row_cnt_q;
   logic [31:0] rst_cnt_q;
   logic first_rolling_q;
   logic sync_q;
   logic sync_pulse_q;
   logic [15:0] pulse_cnt_q;
   logic trig_meta_q;
   logic trig_sync_q;
   logic fv_q;
   logic [11:0] pix_q;
   logic pix_v_q;

   // Bus decode
   wire bus_wr = psel && penable && pwrite && pready_q;
   wire bus_rd = psel && penable && !pwrite && pready_q;
   wire hit_ctrl = paddr == seq_pkg::ctrl_addr;
   wire hit_cmd = paddr == seq_pkg::cmd_addr;
   wire hit_timing = paddr == seq_pkg::timing_addr;
   wire hit_sync = paddr == seq_pkg::sync_addr;
   wire hit_gain = paddr[7:4] == seq_pkg::gain_addr[7:4];
   wire hit_status = paddr == seq_pkg::status_addr;
   wire [1:0] gain_idx = paddr[3:2];
   wire mapped = hit_ctrl || hit_cmd || hit_timing || hit_sync || hit_gain || hit_status;
   wire restart_wr = bus_wr && hit_cmd && pwdata[seq_pkg::restart_bit];
   wire trig_wr = bus_wr && hit_cmd && pwdata[seq_pkg::trigger_bit];

   // Mode fields
   wire single_shot = ctrl_q[seq_pkg::single_shot_bit];
   wire bulb_hold = ctrl_q[seq_pkg::bulb_hold_bit];
   wire global_rel = ctrl_q[seq_pkg::global_release_bit];
   wire trig_flip = ctrl_q[seq_pkg::trig_flip_bit];
   wire [1:0] lead_pt = sync_cfg_q[seq_pkg::lead_lsb +: 2];
   wire [1:0] trail_pt = sync_cfg_q[seq_pkg::trail_lsb +: 2];
   wire sync_en = sync_cfg_q[seq_pkg::sync_enable_bit];
   wire sync_inv = sync_cfg_q[seq_pkg::sync_invert_bit];

   // Trigger levels; only the second flop is read
   wire pin_first = trig_flip ? trig_sync_q : !trig_sync_q;
   wire pin_second = trig_flip ? !trig_sync_q : trig_sync_q;
   wire first_trig = !single_shot || pin_first || trig_req_q;
   wire row_tick = aclk_q && (aclk_cnt_q == line_aclks_q - 16'h0001);
   wire sw_expired = row_tick && (row_cnt_q + 16'h0001 >= exposure_row_count_q);
   wire bulb_mode = single_shot && bulb_hold;
   wire second_trig = bulb_mode ? (pin_second || restart_q) : sw_expired;
   wire restart_now = restart_q && !(bulb_mode && state_q == seq_pkg::st_expose);
   wire need_allreset = global_rel || first_rolling_q;

   // Sync timepoints
   wire vb_hit = state_q == seq_pkg::st_expose && row_tick
                 && row_cnt_q + 16'h0001 == 16'(vertical_blank_rows_q);
   wire at_expstart = global_rel ? vb_hit : vb_hit; // Rolling: all rows exposing once blank elapses
   wire at_expiry = state_q == seq_pkg::st_expose && sw_expired;
   wire at_second = state_q == seq_pkg::st_expose && second_trig;
   wire lead_hit = (lead_pt == seq_pkg::pt_exposure_start && at_expstart)
                   || (lead_pt == seq_pkg::pt_counter_expiry && at_expiry)
                   || (lead_pt == seq_pkg::pt_second_trigger && at_second);
   wire trail_hit = (trail_pt == seq_pkg::pt_exposure_start && at_expstart)
                    || (trail_pt == seq_pkg::pt_counter_expiry && at_expiry)
                    || (trail_pt == seq_pkg::pt_second_trigger && at_second);
   wire same_pt = lead_pt == trail_pt;
   // Outside frame valid there is no row, so a pulse lasts one array clock
   wire [15:0] pulse_len = fv_q ? 16'(line_aclks_q * seq_pkg::aclk_div) : 16'(seq_pkg::aclk_div);

   // Datapath: 12 bit times (8+g)/8 then offset, clamped to 12 bits
   wire [1:0] ci = pix_colour;
   wire [19:0] prod = 20'(pix_in) * 20'({1'b0, dgain_q[ci]} + 20'd8);
   wire signed [21:0] sum = $signed({2'b00, prod} >>> seq_pkg::gain_frac_bits) + 22'(doffset_q[ci]);
   wire [11:0] pix_clamped = sum < 0 ? 12'h000 : (sum > seq_pkg::pix_max ? 12'hfff : sum[11:0]);

   wire [31:0] rd_mux =
      hit_ctrl ? {28'h0000000, ctrl_q} :
      hit_cmd ? {30'h00000000, restart_q, trig_req_q} :
      hit_timing ? {exposure_row_count_q, line_aclks_q} :
      hit_sync ? {16'h0000, vertical_blank_rows_q, 2'h0, sync_cfg_q} :
      hit_status ? {28'h0000000, fv_q, 3'(state_q)} :
      hit_gain ? {9'h000, dgain_q[gain_idx], 4'h0, doffset_q[gain_idx]} : 32'h00000000;

   // APB slave, one wait state
   always_ff @(posedge pclk or negedge presetn)
   begin
      if (!presetn)
      begin
         pready_q <= 1'b0;
         prdata_q <= 32'h00000000;
         pslverr_q <= 1'b0;
      end
      else
      begin
         pready_q <= psel && penable && !pready_q;
         prdata_q <= (psel && penable && !pready_q) ? rd_mux : prdata_q;
         pslverr_q <= psel && penable && !pready_q && !mapped;
      end
   end

   always_ff @(posedge pclk or negedge presetn)
   begin
      if (!presetn)
      begin
         ctrl_q <= 4'h0;
         exposure_row_count_q <= seq_pkg::exposure_rows_reset;
         line_aclks_q <= seq_pkg::line_aclks_reset;
         vertical_blank_rows_q <= seq_pkg::vblank_reset;
         sync_cfg_q <= {2'h0, seq_pkg::trail_reset, seq_pkg::lead_reset};
      end
      else if (bus_wr && mapped)
      begin
         if (hit_ctrl)
            ctrl_q <= pwdata[3:0];
         if (hit_timing)
         begin
            exposure_row_count_q <= pwdata[31:16];
            line_aclks_q <= pwdata[15:0];
         end
         if (hit_sync)
         begin
            vertical_blank_rows_q <= pwdata[15:8];
            sync_cfg_q <= pwdata[5:0];
         end
      end
   end

   genvar g;
   generate
      for (g = 0; g < 4; g++)
      begin : gain_regs
         always_ff @(posedge pclk or negedge presetn)
         begin
            if (!presetn)
            begin
               dgain_q[g] <= seq_pkg::dgain_reset;
               doffset_q[g] <= 12'h000;
            end
            else if (bus_wr && hit_gain && gain_idx == g)
            begin
               dgain_q[g] <= pwdata[22:16] > 7'd120 ? 7'd120 : pwdata[22:16]; // Gain capped at 16
               doffset_q[g] <= pwdata[11:0];
            end
         end
      end
   endgenerate

   // Trigger pin synchroniser
   always_ff @(posedge pclk or negedge presetn)
   begin
      if (!presetn)
      begin
         trig_meta_q <= 1'b1;
         trig_sync_q <= 1'b1;
      end
      else
      begin
         trig_meta_q <= trigger_pin;
         trig_sync_q <= trig_meta_q;
      end
   end

   // Command fields: set wins over clear
   always_ff @(posedge pclk or negedge presetn)
   begin
      if (!presetn)
      begin
         restart_q <= 1'b0;
         trig_req_q <= 1'b0;
      end
      else
      begin
         restart_q <= restart_wr || (restart_q && !(restart_now || (state_q == seq_pkg::st_expose && bulb_mode)));
         trig_req_q <= trig_wr || (trig_req_q && !(state_q == seq_pkg::st_wait_first));
      end
   end

   // Array clock and row timing
   always_ff @(posedge pclk or negedge presetn)
   begin
      if (!presetn)
      begin
         aclk_q <= 1'b0;
         aclk_cnt_q <= 16'h0000;
      end
      else
      begin
         aclk_q <= !aclk_q;
         if (row_tick || state_q == seq_pkg::st_wait_first)
            aclk_cnt_q <= 16'h0000;
         else if (aclk_q)
            aclk_cnt_q <= aclk_cnt_q + 16'h0001;
      end
   end

   // Capture sequence
   always_ff @(posedge pclk or negedge presetn)
   begin
      if (!presetn)
      begin
         state_q <= seq_pkg::st_allreset;
         rst_cnt_q <= 32'h00000000;
         row_cnt_q <= 16'h0000;
         first_rolling_q <= 1'b1;
         fv_q <= 1'b0;
      end
      else if (restart_now)
      begin
         state_q <= seq_pkg::st_allreset;
         rst_cnt_q <= 32'h00000000;
         row_cnt_q <= 16'h0000;
         first_rolling_q <= 1'b1;
         fv_q <= 1'b0;
      end
      else
      begin
         case (state_q)
            seq_pkg::st_allreset:
            begin
               rst_cnt_q <= rst_cnt_q + 32'h00000001;
               if (!need_allreset || rst_cnt_q >= 32'(all_reset_cycles - 1))
               begin
                  state_q <= seq_pkg::st_wait_first;
                  first_rolling_q <= 1'b0;
               end
            end
            seq_pkg::st_wait_first:
               if (first_trig)
               begin
                  state_q <= seq_pkg::st_expose;
                  row_cnt_q <= 16'h0000;
               end
            seq_pkg::st_expose:
            begin
               if (row_tick)
                  row_cnt_q <= row_cnt_q + 16'h0001;
               if (second_trig)
               begin
                  state_q <= seq_pkg::st_readout;
                  row_cnt_q <= 16'h0000;
                  fv_q <= 1'b1;
               end
            end
            seq_pkg::st_readout:
            begin
               if (row_tick)
                  row_cnt_q <= row_cnt_q + 16'h0001;
               if (row_tick && row_cnt_q == 16'(frame_rows - 1))
               begin
                  state_q <= seq_pkg::st_blank;
                  row_cnt_q <= 16'h0000;
                  fv_q <= 1'b0;
               end
            end
            seq_pkg::st_blank:
            begin
               if (row_tick)
                  row_cnt_q <= row_cnt_q + 16'h0001;
               // Global frames redo the all-rows reset straight away
               if (global_rel)
               begin
                  state_q <= seq_pkg::st_allreset;
                  rst_cnt_q <= 32'h00000000;
               end
               // Waiting again by blank minus 8 rows, so a legal early trigger is caught
               else if (row_tick && row_cnt_q + 16'h0001 + 16'(seq_pkg::blank_guard_rows)
                        >= 16'(vertical_blank_rows_q))
                  state_q <= seq_pkg::st_wait_first;
            end
            default:
               state_q <= seq_pkg::st_allreset;
         endcase
      end
   end

   // Sync generation
   always_ff @(posedge pclk or negedge presetn)
   begin
      if (!presetn)
      begin
         sync_q <= 1'b0;
         sync_pulse_q <= 1'b0;
         pulse_cnt_q <= 16'h0000;
      end
      else if (same_pt)
      begin
         sync_q <= 1'b0;
         if (lead_hit)
         begin
            sync_pulse_q <= 1'b1;
            pulse_cnt_q <= pulse_len - 16'h0001;
         end
         else if (pulse_cnt_q != 16'h0000)
            pulse_cnt_q <= pulse_cnt_q - 16'h0001;
         else
            sync_pulse_q <= 1'b0;
      end
      else
      begin
         sync_pulse_q <= 1'b0;
         pulse_cnt_q <= 16'h0000;
         if (lead_hit)
            sync_q <= 1'b1;
         else if (trail_hit || state_q == seq_pkg::st_allreset)
            sync_q <= 1'b0;
      end
   end

   // Outputs, all registered
   always_ff @(posedge pclk or negedge presetn)
   begin
      if (!presetn)
      begin
         sync_out <= 1'b0;
         sync_oe_n <= 1'b1;
         pix_q <= 12'h000;
         pix_v_q <= 1'b0;
      end
      else
      begin
         sync_out <= (sync_q || sync_pulse_q) ^ sync_inv;
         sync_oe_n <= !sync_en;
         pix_q <= pix_clamped;
         pix_v_q <= pix_valid_in && fv_q;
      end
   end

   assign prdata = prdata_q;
   assign pready = pready_q;
   assign pslverr = pslverr_q;
   assign pix_out = pix_q;
   assign pix_valid_out = pix_v_q;
   assign frame_valid = fv_q;
endmodule : exposure_trigger_strobe_sequencer

// ===== dv/exposure_trigger_strobe_sequencer_assertions.sv
`timescale 1ns/100ps
module sequencer_checker #(
   parameter int all_reset_cycles = 40
)(
   input wire logic pclk,
   input wire logic presetn,
   input wire logic psel,
   input wire logic penable,
   input wire logic pwrite,
   input wire logic [7:0] paddr,
   input wire logic pready,
   input wire logic pslverr,
   input wire logic pix_valid_in,
   input wire logic pix_valid_out,
   input wire logic frame_valid,
   input wire logic sync_oe_n
);
   logic [31:0] boot_q;
   logic sync_wr;
   // Saturates so a long run cannot wrap back under the limit
   always_ff @(posedge pclk or negedge presetn)
      if (!presetn)
         boot_q <= 32'h0;
      else if (boot_q < 32'(all_reset_cycles))
         boot_q <= boot_q + 32'h1;
   assign sync_wr = psel && penable && pready && pwrite && paddr == seq_pkg::sync_addr;
   default clocking cb @(posedge pclk);
   endclocking
   default disable iff (!presetn);
   access_wait_a: assert property (psel && !penable |=> !pready)
      else $error("ready came without a wait cycle");
   ready_pulse_a: assert property (pready |=> !pready)
      else $error("ready held longer than one cycle");
   ready_phase_a: assert property (pready |-> psel && penable)
      else $error("ready outside an access phase");
   err_ready_a: assert property (pslverr |-> pready)
      else $error("error flag without ready");
   pix_gate_a: assert property (1'b1 |-> pix_valid_out == ($past(pix_valid_in) && $past(frame_valid)))
      else $error("pixel valid not gated by frame valid");
   sync_drive_a: assert property (!$stable(sync_oe_n) |-> $past(sync_wr) || $past(sync_wr, 2))
      else $error("sync drive changed without a sync write");
   reset_hold_a: assert property (frame_valid |-> boot_q >= 32'(all_reset_cycles))
      else $error("frame before the all-rows reset ended");
   frame_hold_a: assert property ($rose(frame_valid) |=> frame_valid [*4])
      else $error("readout shorter than expected");
endmodule : sequencer_checker

bind exposure_trigger_strobe_sequencer sequencer_checker #(.all_reset_cycles(all_reset_cycles)) chk_i (
   .pclk, .presetn, .psel, .penable, .pwrite, .paddr, .pready, .pslverr,
   .pix_valid_in, .pix_valid_out, .frame_valid, .sync_oe_n);

// ===== dv/trigger_host_model.sv
`timescale 1ns/100ps
module trigger_host_model #(
   parameter int hold_cycles = 600
)(
   input wire logic pclk,
   input wire logic arm,
   input wire logic flip,
   output logic trigger_pin
);
   int cnt_q = 0;
   // Pulse outlasts four line periods so bulb exposure is legal
   always_ff @(posedge pclk)
      if (arm && cnt_q == 0)
         cnt_q <= hold_cycles;
      else if (cnt_q > 0)
         cnt_q <= cnt_q - 1;
   // Pin always driven; idle sits at the inactive level
   assign trigger_pin = (cnt_q > 0) ? flip : ~flip;
endmodule : trigger_host_model

// ===== dv/test_exposure_trigger_strobe_sequencer.sv
`timescale 1ns/100ps
module test_exposure_trigger_strobe_sequencer;
   typedef struct {logic wr; logic [7:0] a; logic [31:0] d; logic [31:0] rd; logic err;} apb_row_t;
   typedef struct {logic [1:0] c; logic [31:0] g; logic [11:0] p; logic [11:0] q;} pix_row_t;
   logic pclk = 1'b0;
   logic presetn = 1'b0;
   logic psel = 1'b0;
   logic penable = 1'b0;
   logic pwrite = 1'b0;
   logic [7:0] paddr = 8'h00;
   logic [31:0] pwdata = 32'h0;
   logic [31:0] prdata;
   logic pready;
   logic pslverr;
   logic trigger_pin;
   logic pix_valid_in = 1'b1;
   logic [11:0] pix_in = 12'h000;
   logic [1:0] pix_colour = 2'h0;
   logic [11:0] pix_out;
   logic pix_valid_out;
   logic frame_valid;
   logic sync_out;
   logic sync_oe_n;
   logic arm = 1'b0;
   logic flip = 1'b0;
   logic [31:0] rd;
   logic err;
   int fail_count = 0;
   int n_compared = 0;
   int sync_hi = 0;
   int i;
   apb_row_t rows [8] = '{
      '{1'b0, 8'h00, 32'h0, 32'h00000000, 1'b0},
      '{1'b0, 8'h08, 32'h0, 32'h00100040, 1'b0},
      '{1'b0, 8'h0c, 32'h0, 32'h0000190d, 1'b0},
      '{1'b0, 8'h10, 32'h0, 32'h00000000, 1'b0},
      '{1'b1, 8'h20, 32'h5, 32'h00000000, 1'b1},
      '{1'b0, 8'h20, 32'h0, 32'h00000000, 1'b1},
      '{1'b1, 8'h00, 32'h8, 32'h00000000, 1'b0},
      '{1'b0, 8'h00, 32'h0, 32'h00000008, 1'b0}};
   // Gain 1 + g/8, offset signed, result clamped to 12 bits
   pix_row_t pixs [4] = '{
      '{2'h0, 32'h00080ff0, 12'h064, 12'h0b8},
      '{2'h1, 32'h00780000, 12'hfff, 12'hfff},
      '{2'h2, 32'h00000800, 12'h00a, 12'h000},
      '{2'h3, 32'h00040007, 12'h3e8, 12'h5e3}};

   always #20 pclk = ~pclk;

   always @(posedge pclk)
      if (sync_out === 1'b1)
         sync_hi++;

   exposure_trigger_strobe_sequencer #(.frame_rows(4), .all_reset_cycles(40)) DUT (
      .pclk, .presetn, .psel, .penable, .pwrite, .paddr, .pwdata, .prdata, .pready, .pslverr,
      .trigger_pin, .pix_valid_in, .pix_in, .pix_colour, .pix_out, .pix_valid_out,
      .frame_valid, .sync_out, .sync_oe_n);

   trigger_host_model host (.pclk, .arm, .flip, .trigger_pin);

   task automatic end_sim();
      $display("compared %0d, mismatches %0d", n_compared, fail_count);
      if (fail_count == 0 && n_compared > 0)
         $display("SIMULATION PASSED");
      else
         $display("SIMULATION FAILED");
      $finish;
   endtask : end_sim

   task automatic chk(input logic [31:0] seen, input logic [31:0] exp);
      n_compared++;
      if (seen !== exp)
      begin
         fail_count++;
         $display("[FAIL] %0t seen %h expected %h", $time, seen, exp);
      end
   endtask : chk

   task automatic apb(input logic wr, input logic [7:0] a, input logic [31:0] d);
      int n;
      @(posedge pclk);
      psel <= 1'b1;
      pwrite <= wr;
      paddr <= a;
      pwdata <= d;
      @(posedge pclk);
      penable <= 1'b1;
      for (n = 0; n < 16; n++)
      begin
         @(posedge pclk);
         if (pready === 1'b1)
            break;
      end
      rd = prdata;
      err = pslverr;
      psel <= 1'b0;
      penable <= 1'b0;
      if (n == 16)
      begin
         fail_count++;
         end_sim();
      end
   endtask : apb

   // Bounded wait on the frame flag; a hang ends the run
   task automatic wait_fv(input logic v, input int lim);
      int n;
      for (n = 0; n < lim; n++)
      begin
         @(posedge pclk);
         if (frame_valid === v)
            return;
      end
      fail_count++;
      end_sim();
   endtask : wait_fv

   task automatic pulse_arm();
      arm <= 1'b1;
      @(posedge pclk);
      arm <= 1'b0;
   endtask : pulse_arm

   initial
   begin
      repeat (12) @(posedge pclk);
      chk(32'(frame_valid), 32'h0);
      chk(32'(sync_oe_n), 32'h1);
      presetn <= 1'b1;
      foreach (rows[k])
      begin
         apb(rows[k].wr, rows[k].a, rows[k].d);
         chk(32'(err), 32'(rows[k].err));
         if (!rows[k].wr)
            chk(rd, rows[k].rd);
      end
      apb(1'b1, seq_pkg::ctrl_addr, 32'h0);
      foreach (pixs[k])
      begin
         apb(1'b1, seq_pkg::gain_addr + {4'h0, pixs[k].c, 2'h0}, pixs[k].g);
         pix_colour <= pixs[k].c;
         pix_in <= pixs[k].p;
         repeat (2) @(posedge pclk);
         chk(32'(pix_out), 32'(pixs[k].q));
      end
      wait_fv(1'b1, 5000);
      apb(1'b1, seq_pkg::ctrl_addr, 32'h1);
      wait_fv(1'b0, 2000);
      apb(1'b1, seq_pkg::sync_addr, 32'h191f);
      repeat (4) @(posedge pclk);
      chk(32'(sync_oe_n), 32'h0);
      chk(32'(sync_out), 32'h0);
      apb(1'b1, seq_pkg::sync_addr, 32'h193f);
      repeat (4) @(posedge pclk);
      chk(32'(sync_out), 32'h1);
      apb(1'b1, seq_pkg::sync_addr, 32'h191f);
      repeat (4) @(posedge pclk);
      sync_hi = 0;
      i = 0;
      repeat (4000)
      begin
         @(posedge pclk);
         i += int'(frame_valid !== 1'b0);
      end
      chk(32'(i), 32'h0);
      apb(1'b1, seq_pkg::cmd_addr, 32'h1);
      wait_fv(1'b1, 5000);
      wait_fv(1'b0, 2000);
      repeat (2200) @(posedge pclk); // Host keeps blank minus 8 rows
      // Second trigger comes after the previous frame ended: one array clock wide
      chk(32'(sync_hi), 32'h2);
      pulse_arm();
      wait_fv(1'b1, 5000);
      // Polarity swapped mid-frame, while no first trigger is awaited
      apb(1'b1, seq_pkg::ctrl_addr, 32'h9);
      flip <= 1'b1;
      wait_fv(1'b0, 2000);
      repeat (2200) @(posedge pclk);
      pulse_arm();
      wait_fv(1'b1, 5000);
      apb(1'b1, seq_pkg::ctrl_addr, 32'h3);
      flip <= 1'b0;
      wait_fv(1'b0, 2000);
      repeat (2200) @(posedge pclk);
      pulse_arm();
      repeat (590) @(posedge pclk);
      chk(32'(frame_valid), 32'h0);
      wait_fv(1'b1, 1500);
      apb(1'b1, seq_pkg::ctrl_addr, 32'h5);
      wait_fv(1'b0, 2000);
      repeat (2200) @(posedge pclk);
      apb(1'b1, seq_pkg::cmd_addr, 32'h1);
      repeat (2000) @(posedge pclk);
      chk(32'(frame_valid), 32'h0);
      wait_fv(1'b1, 1500);
      wait_fv(1'b0, 2000);
      apb(1'b1, seq_pkg::ctrl_addr, 32'h0);
      apb(1'b1, seq_pkg::cmd_addr, 32'h2);
      repeat (8) @(posedge pclk);
      apb(1'b0, seq_pkg::cmd_addr, 32'h0);
      chk(rd & 32'h2, 32'h0);
      wait_fv(1'b1, 8000);
      wait_fv(1'b0, 2000);
      wait_fv(1'b1, 8000);
      presetn <= 1'b0;
      repeat (2) @(posedge pclk);
      chk(32'(frame_valid), 32'h0);
      chk(32'(sync_oe_n), 32'h1);
      end_sim();
   end
endmodule : test_exposure_trigger_strobe_sequencer
